// >>> inc/csp_pkg.sv
// Constants and types for the codec serial port framing block
package csp_pkg;

   // Word and byte geometry
   localparam int          CSP_WORD_W     = 16;
   localparam int          CSP_BYTE_W     = 8;
   localparam int          CSP_FIFO_DEPTH = 8;

   // Shift clock is the master clock divided by four
   localparam int          CSP_SCLK_DIV   = 4;
   localparam int          CSP_PH_W       = $clog2(CSP_SCLK_DIV);
   localparam logic [1:0]  CSP_PH_LAST    = 2'h3;
   localparam logic [1:0]  CSP_SCLK_HI    = 2'h2;

   // Bit counter
   localparam int          CSP_BIT_W      = 5;
   localparam logic [4:0]  CSP_WORD_LAST  = 5'h0f;
   localparam logic [4:0]  CSP_BYTE_LAST  = 5'h07;

   // Conversion strobe period in shift clock periods
   localparam int          CSP_FRAME_DIV  = 64;
   localparam int          CSP_CONV_W     = 8;

   // Frame sync low time of a word frame, in master clocks
   localparam int          CSP_LOWCNT_W   = 7;
   localparam logic [6:0]  CSP_WORD_LOW_CYC = 7'h40;

   typedef enum logic [2:0] {
      CSP_IDLE,
      CSP_PREP,
      CSP_XFER,
      CSP_GAP,
      CSP_END
   } csp_state_t;

   // Pins toward the host serial port
   typedef struct packed {
      logic shift_clk;
      logic tx_frame_sync_n;
      logic rx_frame_sync_n;
      logic tx_word_end_strobe_n;
      logic rx_word_end_strobe_n;
      logic serial_out_to_host;
   } csp_pins_t;

   localparam csp_pins_t CSP_PINS_RST = 6'h3e;

   // Word received from the host
   typedef struct packed {
      logic                  valid;
      logic                  secondary;
      logic [CSP_WORD_W-1:0] data;
   } csp_host_word_t;

endpackage

// >>> design/csp_framer.sv
// Serial port framing of a converter device: shift clock, frame syncs, end strobes
`timescale 1ns/100ps
// Behaviour
// [R1] Word mode: one low pulse on transmit end strobe after 16 inbound bits.
// [R2] Byte mode: transmit end strobe low from first byte end until second byte done.
// [R3] Receive frame sync low during outbound bits; host captures from its fall.
// [R4] Outbound MSB sits on the serial output before receive frame sync falls.
// [R5] No receive frame sync during secondary transfers.
// [R6] Transmit frame sync low for whole inbound transfer; host shifts from its fall.
// [R7] Shift clock and conversion strobes are synchronous submultiples of master clock.
// [R8] Shift clock is master clock divided by four.
// [R9] Inbound bits move in step with the device shift clock.
// [R10] Word mode: one low pulse on receive end strobe; none after secondary.
// [R11] MSB first, one bit per shift period, sampled on the opposite edge.

module csp_fifo
#(
   parameter int W     = 16,
   parameter int DEPTH = 8
)
(
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
   localparam logic [AW:0]   FULL_CNT = (AW + 1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [AW:0]             cnt;
   } csp_fifo_st_t;

   csp_fifo_st_t r_reg;
   csp_fifo_st_t r_next;
   logic         push;
   logic         pop;

   assign in_ready  = (r_reg.cnt != FULL_CNT);
   assign out_valid = (r_reg.cnt != '0);
   assign out_data  = r_reg.mem[r_reg.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb
   begin
      r_next = r_reg;
      if (push)
      begin
         r_next.mem[r_reg.wp] = in_data;
         r_next.wp = (r_reg.wp == LAST_IDX) ? '0 : r_reg.wp + 1'b1;
      end
      if (pop)
      begin
         r_next.rp = (r_reg.rp == LAST_IDX) ? '0 : r_reg.rp + 1'b1;
      end
      if (push && !pop)
      begin
         r_next.cnt = r_reg.cnt + 1'b1;
      end
      else if (pop && !push)
      begin
         r_next.cnt = r_reg.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         r_reg <= '0;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   chk_fifo_count: assert property (@(posedge clk) disable iff (!nrst)
      r_reg.cnt <= FULL_CNT)
      else $error("fifo count above depth");
endmodule

module csp_framer
   import csp_pkg::*;
#(
   parameter int FRAME_DIV = csp_pkg::CSP_FRAME_DIV,
   parameter int DEPTH     = csp_pkg::CSP_FIFO_DEPTH
)
(
   input  wire logic                           clk,
   input  wire logic                           nrst,
   input  wire logic                           byte_mode,
   input  wire logic [csp_pkg::CSP_WORD_W-1:0] adc_word,
   input  wire logic                           adc_valid,
   output logic                                adc_ready,
   input  wire logic                           sec_req,
   output logic                                sec_ack,
   input  wire logic                           serial_in_from_host,
   output csp_pkg::csp_pins_t                  pins,
   output csp_pkg::csp_host_word_t             host_word
);
   import csp_pkg::*;

   localparam logic [CSP_CONV_W-1:0] CONV_LAST = CSP_CONV_W'(FRAME_DIV - 1);

   typedef struct packed {
      logic [CSP_PH_W-1:0]     phase;
      logic [CSP_CONV_W-1:0]   conv_cnt;
      csp_state_t              state;
      logic [CSP_BIT_W-1:0]    bit_cnt;
      logic                    byte_frame;
      logic                    second_byte;
      logic                    secondary;
      logic                    sec_pend;
      logic                    sec_ack;
      logic                    din_s1;
      logic                    din_s2;
      logic [CSP_WORD_W-1:0]   out_sr;
      logic [CSP_WORD_W-1:0]   in_sr;
      logic [CSP_LOWCNT_W-1:0] fs_low_cnt;
      csp_pins_t               pins;
      csp_host_word_t          word;
   } csp_top_st_t;

   csp_top_st_t           r_reg;
   csp_top_st_t           r_next;
   logic                  adv;
   logic                  conv_tick;
   logic                  pop;
   logic                  fifo_valid;
   logic [CSP_WORD_W-1:0] fifo_data;
   logic [CSP_BIT_W-1:0]  last_bit;

   // Outbound converter words wait here until a conversion strobe
   csp_fifo #(
      .W     (CSP_WORD_W),
      .DEPTH (DEPTH)
   ) csp_fifo_inst (
      .clk       (clk),
      .nrst      (nrst),
      .in_valid  (adc_valid),
      .in_ready  (adc_ready),
      .in_data   (adc_word),
      .out_valid (fifo_valid),
      .out_ready (pop),
      .out_data  (fifo_data)
   );

   // One step per shift period, taken on the last master clock of it
   assign adv       = (r_reg.phase == CSP_PH_LAST);                       // [R7]
   assign conv_tick = adv && (r_reg.conv_cnt == CONV_LAST);               // [R7]
   assign last_bit  = r_reg.byte_frame ? CSP_BYTE_LAST : CSP_WORD_LAST;

   assign pins      = r_reg.pins;
   assign host_word = r_reg.word;
   assign sec_ack   = r_reg.sec_ack;

   always_comb
   begin
      r_next = r_reg;
      pop = 1'b0;
      r_next.word.valid = 1'b0;
      r_next.sec_ack = 1'b0;
      r_next.din_s1 = serial_in_from_host;
      r_next.din_s2 = r_reg.din_s1;
      r_next.phase = r_reg.phase + 1'b1;
      r_next.pins.shift_clk = (r_next.phase < CSP_SCLK_HI);                // [R8]
      r_next.fs_low_cnt = r_reg.pins.tx_frame_sync_n ? '0 : r_reg.fs_low_cnt + 1'b1;
      if (adv)
      begin
         r_next.conv_cnt = conv_tick ? '0 : r_reg.conv_cnt + 1'b1;
         case (r_reg.state)
            CSP_IDLE:
            begin
               if (conv_tick && fifo_valid)
               begin
                  // MSB goes out one shift period ahead of the sync
                  pop = 1'b1;
                  r_next.out_sr = fifo_data;
                  r_next.pins.serial_out_to_host = fifo_data[CSP_WORD_W-1];   // [R4]
                  r_next.secondary = 1'b0;
                  r_next.byte_frame = byte_mode;
                  r_next.state = CSP_PREP;
               end
               else if (r_reg.sec_pend)
               begin
                  r_next.out_sr = '0;
                  r_next.pins.serial_out_to_host = 1'b0;
                  r_next.secondary = 1'b1;
                  r_next.sec_pend = 1'b0;
                  r_next.sec_ack = 1'b1;
                  r_next.byte_frame = byte_mode;
                  r_next.state = CSP_PREP;
               end
            end
            CSP_PREP:
            begin
               r_next.pins.tx_frame_sync_n = 1'b0;                          // [R6]
               r_next.pins.rx_frame_sync_n = r_reg.secondary;               // [R3] [R5]
               r_next.bit_cnt = '0;
               r_next.second_byte = 1'b0;
               r_next.state = CSP_XFER;
            end
            CSP_XFER:
            begin
               // Sample inbound bit while shift clock is low
               r_next.in_sr = {r_reg.in_sr[CSP_WORD_W-2:0], r_reg.din_s2};  // [R9] [R11]
               r_next.out_sr = r_reg.out_sr << 1;
               r_next.pins.serial_out_to_host = r_reg.out_sr[CSP_WORD_W-2]; // [R11]
               r_next.bit_cnt = r_reg.bit_cnt + 1'b1;
               if (r_reg.bit_cnt == last_bit)
               begin
                  r_next.pins.tx_frame_sync_n = 1'b1;
                  r_next.pins.rx_frame_sync_n = 1'b1;
                  if (r_reg.byte_frame && !r_reg.second_byte)
                  begin
                     r_next.pins.tx_word_end_strobe_n = 1'b0;               // [R2]
                     r_next.pins.rx_word_end_strobe_n = r_reg.secondary;    // [R10]
                     r_next.second_byte = 1'b1;
                     r_next.state = CSP_GAP;
                  end
                  else
                  begin
                     r_next.word.valid = 1'b1;
                     r_next.word.secondary = r_reg.secondary;
                     r_next.word.data = {r_reg.in_sr[CSP_WORD_W-2:0], r_reg.din_s2};
                     if (r_reg.byte_frame)
                     begin
                        r_next.pins.tx_word_end_strobe_n = 1'b1;            // [R2]
                        r_next.pins.rx_word_end_strobe_n = 1'b1;
                        r_next.state = CSP_IDLE;
                     end
                     else
                     begin
                        r_next.pins.tx_word_end_strobe_n = 1'b0;            // [R1]
                        r_next.pins.rx_word_end_strobe_n = r_reg.secondary; // [R10]
                        r_next.state = CSP_END;
                     end
                  end
               end
            end
            CSP_GAP:
            begin
               r_next.pins.tx_frame_sync_n = 1'b0;                          // [R6]
               r_next.pins.rx_frame_sync_n = r_reg.secondary;               // [R3] [R5]
               r_next.bit_cnt = '0;
               r_next.state = CSP_XFER;
            end
            CSP_END:
            begin
               r_next.pins.tx_word_end_strobe_n = 1'b1;                     // [R1]
               r_next.pins.rx_word_end_strobe_n = 1'b1;                     // [R10]
               r_next.state = CSP_IDLE;
            end
            default:
            begin
               r_next.state = CSP_IDLE;
            end
         endcase
      end
      // A request in the cycle it is taken stays pending
      if (sec_req)
      begin
         r_next.sec_pend = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         r_reg <= '0;
         r_reg.pins <= CSP_PINS_RST;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   chk_sclk_div_four: assert property (@(posedge clk) disable iff (!nrst)  // [R8]
      $rose(pins.shift_clk) |-> pins.shift_clk [*2] ##1 !pins.shift_clk [*2] ##1 pins.shift_clk)
      else $error("shift clock is not master clock divided by four");

   chk_sync_on_rise: assert property (@(posedge clk) disable iff (!nrst)   // [R7]
      $fell(pins.tx_frame_sync_n) |-> $rose(pins.shift_clk))
      else $error("frame sync not aligned to shift clock");

   chk_word_frame_len: assert property (@(posedge clk) disable iff (!nrst) // [R6]
      $rose(pins.tx_frame_sync_n) && !r_reg.byte_frame |-> r_reg.fs_low_cnt == CSP_WORD_LOW_CYC)
      else $error("word frame sync not low for sixteen bits");

   chk_rx_tx_sync: assert property (@(posedge clk) disable iff (!nrst)     // [R3]
      !r_reg.secondary |-> pins.rx_frame_sync_n == pins.tx_frame_sync_n)
      else $error("receive sync differs from transmit sync in primary frame");

   chk_no_sec_rx_sync: assert property (@(posedge clk) disable iff (!nrst) // [R5]
      r_reg.secondary |-> pins.rx_frame_sync_n)
      else $error("receive sync asserted in secondary transfer");

   chk_msb_before_sync: assert property (@(posedge clk) disable iff (!nrst) // [R4]
      $fell(pins.rx_frame_sync_n) |-> $past(pins.serial_out_to_host, 4) == pins.serial_out_to_host)
      else $error("first bit not stable before receive sync fell");

   chk_tx_word_end_strobe_n_word_pulse: assert property (@(posedge clk) disable iff (!nrst) // [R1]
      $fell(pins.tx_word_end_strobe_n) && !r_reg.byte_frame
      |-> !pins.tx_word_end_strobe_n [*4] ##1 pins.tx_word_end_strobe_n)
      else $error("word mode transmit end strobe not one shift period");

   chk_tx_word_end_strobe_n_byte_hold: assert property (@(posedge clk) disable iff (!nrst) // [R2]
      $fell(pins.tx_word_end_strobe_n) && r_reg.byte_frame
      |-> ((!pins.tx_word_end_strobe_n) throughout (##35 1'b1)) ##1 pins.tx_word_end_strobe_n)
      else $error("byte mode transmit end strobe not held over second byte");

   chk_rx_word_end_strobe_n_word_pulse: assert property (@(posedge clk) disable iff (!nrst) // [R10]
      $fell(pins.rx_word_end_strobe_n) && !r_reg.byte_frame
      |-> $fell(pins.tx_word_end_strobe_n) ##1 !pins.rx_word_end_strobe_n [*3] ##1 pins.rx_word_end_strobe_n)
      else $error("word mode receive end strobe malformed");

   chk_no_sec_rx_word_end_strobe_n: assert property (@(posedge clk) disable iff (!nrst)    // [R10]
      r_reg.secondary |-> pins.rx_word_end_strobe_n)
      else $error("receive end strobe after secondary transfer");

   chk_data_on_rise: assert property (@(posedge clk) disable iff (!nrst)   // [R11]
      $changed(pins.serial_out_to_host) |-> $rose(pins.shift_clk))
      else $error("serial output changed away from shift clock rise");
endmodule

// >>> design/placeholder_never.sv
// Holds no logic: the framing block and its fifo live in csp_framer.sv

// >>> tb/csp_host_model.sv
// Host serial port model facing the framing block
`timescale 1ns/100ps
module csp_host_model
   import csp_pkg::*;
(
   input  wire logic                           clk,
   input  wire logic                           nrst,
   input  wire csp_pkg::csp_pins_t             pins,
   input  wire logic [csp_pkg::CSP_WORD_W-1:0] tx_word,
   output logic                                dx,
   output logic [csp_pkg::CSP_WORD_W-1:0]      rx_word
);
   logic       sclk_d;
   logic [3:0] tx_idx;

   // Pins are sampled mid-cycle, so a shift clock edge is seen as it lands
   always_ff @(negedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sclk_d  <= 1'b1;
         tx_idx  <= 4'h0;
         dx      <= 1'b0;
         rx_word <= 16'h0000;
      end
      else
      begin
         sclk_d <= pins.shift_clk;
         if (pins.tx_frame_sync_n)
            dx <= ~dx;                                   // Released line toggles
         else if (pins.shift_clk && !sclk_d)
         begin
            dx     <= tx_word[4'hf - tx_idx];
            tx_idx <= tx_idx + 4'h1;
         end
         if (!pins.rx_frame_sync_n && !pins.shift_clk && sclk_d)
            rx_word <= {rx_word[14:0], pins.serial_out_to_host};
      end
   end
endmodule

// >>> tb/tb_csp_framer.sv
// Self-checking testbench of the serial port framing block
`timescale 1ns/100ps
module tb_csp_framer;
   import csp_pkg::*;
   logic           clk;
   logic           nrst;
   logic           byte_mode;
   logic [15:0]    adc_word;
   logic           adc_valid;
   logic           adc_ready;
   logic           sec_req;
   logic           sec_ack;
   logic           dx;
   csp_pins_t      pins;
   csp_host_word_t host_word;
   logic [15:0]    htx;
   logic [15:0]    hrx;
   logic           sck_d;
   logic           cnt_clr;
   int             num_errors = 0;
   int             n_checks = 0;
   int             n_txs, n_rxs, n_rfs, n_tfs, n_sck, n_ack;

   csp_framer #(.FRAME_DIV(20), .DEPTH(8)) csp_framer_inst (.clk(clk), .nrst(nrst), .byte_mode(byte_mode),
      .adc_word(adc_word), .adc_valid(adc_valid), .adc_ready(adc_ready), .sec_req(sec_req), .sec_ack(sec_ack),
      .serial_in_from_host(dx), .pins(pins), .host_word(host_word));
   csp_host_model csp_host_model_inst (.clk(clk), .nrst(nrst), .pins(pins), .tx_word(htx), .dx(dx), .rx_word(hrx));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Low-time and edge counters of the framing pins, plus a sec_ack high-time counter; cleared only here
   always @(posedge clk)
   begin
      sck_d <= pins.shift_clk;
      if (cnt_clr === 1'b1)
      begin
         n_txs = 0;
         n_rxs = 0;
         n_rfs = 0;
         n_tfs = 0;
         n_sck = 0;
         n_ack = 0;
      end
      else
      begin
         if (pins.tx_word_end_strobe_n === 1'b0) n_txs++;
         if (pins.rx_word_end_strobe_n === 1'b0) n_rxs++;
         if (pins.rx_frame_sync_n === 1'b0) n_rfs++;
         if (pins.tx_frame_sync_n === 1'b0) n_tfs++;
         if (pins.shift_clk === 1'b1 && sck_d === 1'b0) n_sck++;
         if (sec_ack === 1'b1) n_ack++;
      end
   end

   task automatic clr();
      cnt_clr <= 1'b1;
      @(posedge clk);
      cnt_clr <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic timeout();
      num_errors++;
      $display("[FAIL] t=%0t wait ran out got=%h exp=%h", $time, 1'b0, 1'b1);
      stop_test();
   endtask

   task automatic wait_hw();
      for (int i = 0; i < 3000; i++)
      begin
         @(posedge clk);
         #1;
         if (host_word.valid === 1'b1) return;
      end
      timeout();
   endtask

   task automatic push(input logic [15:0] w);
      logic ok;
      @(posedge clk);
      adc_valid <= 1'b1;
      adc_word  <= w;
      for (int i = 0; i < 100; i++)
      begin
         @(negedge clk);
         ok = adc_ready;
         @(posedge clk);
         if (ok === 1'b1)
         begin
            adc_valid <= 1'b0;
            return;
         end
      end
      timeout();
   endtask

   task automatic t_reset();
      @(posedge clk);
      #1;
      chk(pins, CSP_PINS_RST);
      chk(host_word, 18'h00000);
      chk(sec_ack, 1'b0);
      chk(adc_ready, 1'b1);
      @(posedge clk);
      nrst <= 1'b1;
      $display("test reset done");
   endtask

   task automatic t_sclk();
      clr();
      repeat (40) @(posedge clk);
      #1;
      chk(n_sck, 10);
      $display("test shift clock done");
   endtask

   task automatic t_word();
      htx <= 16'ha5c3;
      push(16'h3c5a);
      clr();
      wait_hw();
      chk(host_word.data, 16'ha5c3);
      chk(host_word.secondary, 1'b0);
      repeat (8) @(posedge clk);
      chk(hrx, 16'h3c5a);
      chk(n_txs, 4);
      chk(n_rxs, 4);
      chk(n_rfs, 64);
      chk(n_tfs, 64);
      chk(n_ack, 0);
      $display("test word frame done");
   endtask

   task automatic t_sec();
      clr();
      sec_req <= 1'b1;
      @(posedge clk);
      sec_req <= 1'b0;
      wait_hw();
      chk(host_word.secondary, 1'b1);
      chk(host_word.data, 16'ha5c3);
      chk(n_ack, 1);
      repeat (8) @(posedge clk);
      chk(n_rfs, 0);
      chk(n_rxs, 0);
      chk(n_txs, 4);
      chk(n_tfs, 64);
      $display("test secondary frame done");
   endtask

   task automatic t_byte();
      byte_mode <= 1'b1;
      htx       <= 16'h5ab4;
      push(16'hc3a5);
      clr();
      wait_hw();
      chk(host_word.data, 16'h5ab4);
      repeat (8) @(posedge clk);
      chk(hrx, 16'hc3a5);
      chk(n_txs, 36);
      chk(n_rfs, 64);
      chk(n_tfs, 64);
      byte_mode <= 1'b0;
      $display("test byte frame done");
   endtask

   task automatic t_fifo();
      logic ok;
      int   n;
      n = 0;
      @(posedge clk);
      adc_valid <= 1'b1;
      adc_word  <= 16'h1000;
      for (int i = 0; i < 20; i++)
      begin
         @(negedge clk);
         ok = adc_ready;
         @(posedge clk);
         if (ok !== 1'b1) break;
         n++;
         adc_word <= 16'h1000 + 16'(n);
      end
      adc_valid <= 1'b0;
      chk(n >= 8 && n <= 9, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         wait_hw();
         repeat (8) @(posedge clk);
         chk(hrx, 16'h1000 + 16'(i));
      end
      chk(adc_ready, 1'b1);
      $display("test fifo fill and drain done");
   endtask

   initial
   begin
      nrst      = 1'b0;
      byte_mode = 1'b0;
      adc_word  = 16'h0000;
      adc_valid = 1'b0;
      sec_req   = 1'b0;
      htx       = 16'h0000;
      cnt_clr   = 1'b0;
      t_reset();
      t_sclk();
      t_word();
      t_sec();
      t_byte();
      t_fifo();
      stop_test();
   end
endmodule
